// [aor_top.sv]
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module aor_top #(
  parameter int unsigned HOLD_CYC = aor_pkg::AOR_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire aor_pkg::aor_func_s func_in,
  input wire logic signed [15:0] measured_value,
  input wire logic mode_key,
  output logic [1:0] aux_out,
  output logic aux_out_one_lamp,
  output logic aux_out_two_lamp,
  output logic [3:0] alarm_one_type,
  output logic [3:0] alarm_two_type,
  output logic [3:0] alarm_three_type,
  output logic signed [15:0] target_value,
  output logic signed [16:0] control_error,
  output logic onoff_active,
  output logic [1:0] decimal_point,
  output logic menu_active,
  output logic mode_enter
);
  import aor_pkg::*;

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  aor_src_e aux_src_q [2];
  logic [3:0] atype_q [3];
  logic [2:0] alarm_pol_q;
  logic dir_q, onoff_q;
  logic [1:0] kind_q, sec_q;
  logic signed [15:0] setpoint_high_limit, setpoint_low_limit;
  logic signed [15:0] sc_hi_q, sc_lo_q;
  logic [4:0] intype_q;
  logic fahr_q;
  logic [1:0] sc_dp_q;

  function automatic aor_rng_s sensor_range(input logic [4:0] t,
                                            input logic f);
    aor_rng_s r;
    r = '{hi: 16'sd0, lo: 16'sd0, dp: 2'h0};
    case (t)
      5'h00, 5'h01: r = f ? '{9999, -1999, 1} : '{6500, -1999, 1};
      5'h02, 5'h0b: r = f ? '{2300, -300, 0} : '{1300, -200, 0};
      5'h03: r = f ? '{9000, 0, 1} : '{5000, 0, 1};
      5'h04, 5'h08: r = f ? '{1500, -100, 0} : '{850, -100, 0};
      5'h05, 5'h09: r = f ? '{7500, 0, 1} : '{4000, 0, 1};
      5'h06, 5'h0a: r = f ? '{7000, -1999, 1} : '{4000, -1999, 1};
      5'h07: r = f ? '{1100, 0, 0} : '{600, 0, 0};
      5'h0c, 5'h0d: r = f ? '{3000, 0, 0} : '{1700, 0, 0};
      5'h0e: r = f ? '{3200, 300, 0} : '{1800, 100, 0};
      5'h0f: r = f ? '{4100, 0, 0} : '{2300, 0, 0};
      5'h10: r = f ? '{2300, 0, 0} : '{1300, 0, 0};
      default: r = '{hi: 16'sd0, lo: 16'sd0, dp: 2'h0};
    endcase
    return r;
  endfunction

  function automatic logic signed [15:0] clamp(
      input logic signed [15:0] v, input logic signed [15:0] hi,
      input logic signed [15:0] lo);
    clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  function automatic logic routed(input aor_src_e a, input aor_src_e b,
                                  input int i);
    routed = (a == aor_src_e'(i[3:0])) || (b == aor_src_e'(i[3:0]));
  endfunction

  logic is_temp;
  aor_rng_s sens;
  logic signed [15:0] bound_hi, bound_lo;
  assign is_temp = (intype_q <= AOR_TEMP_LAST);
  assign sens = sensor_range(intype_q, fahr_q);
  assign bound_hi = is_temp ? sens.hi : sc_hi_q;
  assign bound_lo = is_temp ? sens.lo : sc_lo_q;

  // ----------------------------------------------------------------
  // apb decode, checked in the setup phase
  // ----------------------------------------------------------------
  // accept/reject and read data are settled in setup so that the
  // access phase can answer with zero wait states from flip-flops
  logic setup, access, wr_ok_q, wr_go;
  logic [7:0] addr_q;
  logic [31:0] rdata_d;
  logic acc_ok;
  logic signed [15:0] w_hi, w_lo;
  logic [4:0] w_type;
  logic w_unit;
  logic exp_ok;
  aor_rng_s w_sens;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign w_hi = pwdata[15:0];
  assign w_lo = pwdata[AOR_LIM_LO_LSB +: 16];
  assign w_type = pwdata[4:0];
  assign w_unit = pwdata[AOR_IN_UNIT_BIT];
  assign w_sens = sensor_range(w_type, w_unit);
  assign exp_ok = (sec_q <= AOR_SEC_EXP_MAX);

  always_comb begin
    logic [3:0] nt;
    logic [7:0] a;
    nt = 4'h0;
    a = paddr[7:0];
    acc_ok = 1'b1;
    rdata_d = 32'h0;
    if (paddr[31:8] != 24'h0 || paddr[1:0] != 2'h0) begin
      acc_ok = 1'b0;
    end else if (a == AOR_OFS_ROUTE) begin
      rdata_d = {20'h0, aux_src_q[1], 4'h0, aux_src_q[0]};
      if (pwrite && (pwdata[3:0] > AOR_SRC_ADERR ||
          pwdata[AOR_AUX2_LSB +: 4] > AOR_SRC_ADERR))
        acc_ok = 1'b0;
    end else if (a == AOR_OFS_ATYPE) begin
      for (int i = 0; i < 3; i++) begin
        rdata_d[i*AOR_ATYPE_STRIDE +: 4] = atype_q[i];
        nt = pwdata[i*AOR_ATYPE_STRIDE +: 4];
        if (pwrite && nt != atype_q[i] &&
            (!routed(aux_src_q[0], aux_src_q[1], i) ||
             nt < AOR_AT_UPLO || nt > AOR_AT_ABS_LO_SB))
          acc_ok = 1'b0;
      end
    end else if (a == AOR_OFS_POL) begin
      rdata_d = {29'h0, alarm_pol_q};
      for (int i = 0; i < 3; i++) begin
        if (pwrite && pwdata[i] != alarm_pol_q[i] &&
            !routed(aux_src_q[0], aux_src_q[1], i))
          acc_ok = 1'b0;
      end
    end else if (a == AOR_OFS_CTRL) begin
      rdata_d[AOR_CTL_DIR_BIT] = dir_q;
      rdata_d[AOR_CTL_ONOFF_BIT] = onoff_q;
      rdata_d[AOR_CTL_KIND_LSB +: 2] = kind_q;
      rdata_d[AOR_CTL_SEC_LSB +: 2] = sec_q;
      if (pwrite && pwdata[AOR_CTL_ONOFF_BIT] != onoff_q &&
          (!exp_ok || kind_q == AOR_CK_POSITION))
        acc_ok = 1'b0;
      if (pwrite && pwdata[AOR_CTL_KIND_LSB +: 2] > AOR_CK_POSITION)
        acc_ok = 1'b0;
    end else if (a == AOR_OFS_LIMIT) begin
      rdata_d = {setpoint_low_limit, setpoint_high_limit};
      if (pwrite && (!exp_ok || w_hi <= w_lo ||
          w_hi > bound_hi || w_lo < bound_lo))
        acc_ok = 1'b0;
    end else if (a == AOR_OFS_TARGET) begin
      rdata_d = {{16{target_value[15]}}, target_value};
      if (pwrite && (w_hi > setpoint_high_limit ||
          w_hi < setpoint_low_limit))
        acc_ok = 1'b0;
    end else if (a == AOR_OFS_INPUT) begin
      rdata_d[4:0] = intype_q;
      rdata_d[AOR_IN_UNIT_BIT] = fahr_q;
      rdata_d[AOR_IN_DP_LSB +: 2] = sc_dp_q;
      if (pwrite && w_type > AOR_INTYPE_LAST)
        acc_ok = 1'b0;
    end else if (a == AOR_OFS_SCALE) begin
      rdata_d = {sc_lo_q, sc_hi_q};
      if (pwrite && (w_hi <= w_lo || w_hi > AOR_SC_MAX ||
          w_lo < AOR_SC_MIN))
        acc_ok = 1'b0;
    end else if (a == AOR_OFS_STATUS) begin
      rdata_d = {13'h0, onoff_active, decimal_point, menu_active,
                 aux_out_two_lamp, aux_out_one_lamp, aux_out,
                 func_in};
      if (pwrite)
        acc_ok = 1'b0;
    end else begin
      acc_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      wr_ok_q <= 1'b0;
      addr_q <= 8'h0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rdata_d;
      pslverr <= !acc_ok;
      wr_ok_q <= pwrite && acc_ok;
      addr_q <= paddr[7:0];
    end
  end

  assign pready = 1'b1;
  assign wr_go = access && wr_ok_q;

  // ----------------------------------------------------------------
  // routing and alarm configuration
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_src_q[0] <= AOR_AUX1_RST;
      aux_src_q[1] <= AOR_AUX2_RST;
    end else if (wr_go && addr_q == AOR_OFS_ROUTE) begin
      aux_src_q[0] <= aor_src_e'(pwdata[3:0]);
      aux_src_q[1] <= aor_src_e'(pwdata[AOR_AUX2_LSB +: 4]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++)
        atype_q[i] <= AOR_ATYPE_RST;
    end else if (wr_go && addr_q == AOR_OFS_ATYPE) begin
      for (int i = 0; i < 3; i++)
        atype_q[i] <= pwdata[i*AOR_ATYPE_STRIDE +: 4];
    end
  end

  // each bit is one alarm; routing never touches these bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      alarm_pol_q <= AOR_POL_RST;
    else if (wr_go && addr_q == AOR_OFS_POL)
      alarm_pol_q <= pwdata[2:0];
  end

  assign alarm_one_type = atype_q[0];
  assign alarm_two_type = atype_q[1];
  assign alarm_three_type = atype_q[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= AOR_DIR_RST;
      onoff_q <= AOR_ONOFF_RST;
      kind_q <= AOR_CK_STD;
      sec_q <= AOR_SEC_RST;
    end else if (wr_go && addr_q == AOR_OFS_CTRL) begin
      dir_q <= pwdata[AOR_CTL_DIR_BIT];
      onoff_q <= pwdata[AOR_CTL_ONOFF_BIT];
      kind_q <= pwdata[AOR_CTL_KIND_LSB +: 2];
      sec_q <= pwdata[AOR_CTL_SEC_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // input type and scaling
  // ----------------------------------------------------------------
  logic in_wr, in_change;
  assign in_wr = wr_go && addr_q == AOR_OFS_INPUT;
  assign in_change = in_wr && (w_type <= AOR_TEMP_LAST) &&
                     (w_type != intype_q || w_unit != fahr_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intype_q <= AOR_INTYPE_RST;
      fahr_q <= 1'b0;
      sc_dp_q <= AOR_DP_RST;
    end else if (in_wr) begin
      intype_q <= w_type;
      fahr_q <= w_unit;
      sc_dp_q <= pwdata[AOR_IN_DP_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_hi_q <= AOR_SCH_RST;
      sc_lo_q <= AOR_SCL_RST;
    end else if (wr_go && addr_q == AOR_OFS_SCALE) begin
      sc_hi_q <= w_hi;
      sc_lo_q <= w_lo;
    end
  end

  // ----------------------------------------------------------------
  // set point limits and target
  // ----------------------------------------------------------------
  logic lim_wr;
  assign lim_wr = wr_go && addr_q == AOR_OFS_LIMIT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setpoint_high_limit <= AOR_SPH_RST;
      setpoint_low_limit <= AOR_SPL_RST;
    end else if (in_change) begin
      setpoint_high_limit <= w_sens.hi;
      setpoint_low_limit <= w_sens.lo;
    end else if (lim_wr) begin
      setpoint_high_limit <= w_hi;
      setpoint_low_limit <= w_lo;
    end
  end

  // the set point follows the limits in the same edge so no cycle
  // ever shows a set point outside the active interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      target_value <= AOR_TARGET_RST;
    else if (in_change)
      target_value <= clamp(target_value, w_sens.hi, w_sens.lo);
    else if (lim_wr)
      target_value <= clamp(target_value, w_hi, w_lo);
    else if (wr_go && addr_q == AOR_OFS_TARGET)
      target_value <= w_hi;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      decimal_point <= AOR_DP_RST;
    else
      decimal_point <= is_temp ? sens.dp : sc_dp_q;
  end

  // ----------------------------------------------------------------
  // control action
  // ----------------------------------------------------------------
  // positive error asks for more output in either action
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_error <= 17'sh0;
      onoff_active <= 1'b0;
    end else begin
      if (dir_q)
        control_error <= 17'(measured_value - target_value);
      else
        control_error <= 17'(target_value - measured_value);
      onoff_active <= onoff_q && kind_q != AOR_CK_POSITION;
    end
  end

  // ----------------------------------------------------------------
  // output routing
  // ----------------------------------------------------------------
  logic [AOR_NUM_SRC-1:0] func_vec;
  assign func_vec = func_in;

  for (genvar k = 0; k < 2; k++) begin : g_aux
    logic state, inv;
    assign state = func_vec[aux_src_q[k]];
    assign inv = (aux_src_q[k] <= AOR_SRC_ALARM3) &&
                 alarm_pol_q[aux_src_q[k][1:0]];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        aux_out[k] <= 1'b0;
      else
        aux_out[k] <= state ^ inv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_out_one_lamp <= 1'b0;
      aux_out_two_lamp <= 1'b0;
    end else begin
      aux_out_one_lamp <= g_aux[0].state;
      aux_out_two_lamp <= g_aux[1].state;
    end
  end

  // ----------------------------------------------------------------
  // mode key hold timing
  // ----------------------------------------------------------------
  logic key_s1_q, key_s2_q, armed_q;
  logic [31:0] hold_cnt_q;
  aor_key_e key_st_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
    end else begin
      key_s1_q <= mode_key;
      key_s2_q <= key_s1_q;
    end
  end

  // the second hold only counts after the key was let go once, so
  // the first press cannot run straight through into a mode entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_st_q <= AOR_KEY_IDLE;
      hold_cnt_q <= 32'h0;
      armed_q <= 1'b0;
      mode_enter <= 1'b0;
    end else begin
      mode_enter <= 1'b0;
      case (key_st_q)
        AOR_KEY_IDLE: begin
          hold_cnt_q <= 32'h0;
          if (key_s2_q)
            key_st_q <= AOR_KEY_HOLD;
        end
        AOR_KEY_HOLD: begin
          if (!key_s2_q) begin
            key_st_q <= AOR_KEY_IDLE;
          end else if (hold_cnt_q >= HOLD_CYC - 2) begin
            key_st_q <= AOR_KEY_MENU;
            armed_q <= 1'b0;
          end else begin
            hold_cnt_q <= hold_cnt_q + 32'h1;
          end
        end
        AOR_KEY_MENU: begin
          hold_cnt_q <= 32'h0;
          if (!key_s2_q)
            armed_q <= 1'b1;
          else if (armed_q)
            key_st_q <= AOR_KEY_MHOLD;
        end
        AOR_KEY_MHOLD: begin
          if (!key_s2_q) begin
            key_st_q <= AOR_KEY_MENU;
          end else if (hold_cnt_q >= HOLD_CYC - 2) begin
            key_st_q <= AOR_KEY_IDLE;
            mode_enter <= 1'b1;
          end else begin
            hold_cnt_q <= hold_cnt_q + 32'h1;
          end
        end
        default: key_st_q <= AOR_KEY_IDLE;
      endcase
    end
  end

  assign menu_active = (key_st_q == AOR_KEY_MENU) ||
                       (key_st_q == AOR_KEY_MHOLD);

endmodule // aor_top

// [aor_pkg.sv]
package aor_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned AOR_CLK_HZ = 50_000_000;
  localparam int unsigned AOR_HOLD_MS = 1000;
  localparam int unsigned AOR_HOLD_CYC = AOR_CLK_HZ / 1000 * AOR_HOLD_MS;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] AOR_OFS_ROUTE = 8'h00;
  localparam logic [7:0] AOR_OFS_ATYPE = 8'h04;
  localparam logic [7:0] AOR_OFS_POL = 8'h08;
  localparam logic [7:0] AOR_OFS_CTRL = 8'h0c;
  localparam logic [7:0] AOR_OFS_LIMIT = 8'h10;
  localparam logic [7:0] AOR_OFS_TARGET = 8'h14;
  localparam logic [7:0] AOR_OFS_INPUT = 8'h18;
  localparam logic [7:0] AOR_OFS_SCALE = 8'h1c;
  localparam logic [7:0] AOR_OFS_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int AOR_AUX2_LSB = 8;
  localparam int AOR_ATYPE_STRIDE = 8;
  localparam int AOR_CTL_DIR_BIT = 0;
  localparam int AOR_CTL_ONOFF_BIT = 1;
  localparam int AOR_CTL_KIND_LSB = 4;
  localparam int AOR_CTL_SEC_LSB = 8;
  localparam int AOR_LIM_LO_LSB = 16;
  localparam int AOR_IN_UNIT_BIT = 8;
  localparam int AOR_IN_DP_LSB = 12;

  // ----------------------------------------------------------------
  // output sources and alarm codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    AOR_SRC_ALARM1 = 4'h0,
    AOR_SRC_ALARM2 = 4'h1,
    AOR_SRC_ALARM3 = 4'h2,
    AOR_SRC_HEATER = 4'h3,
    AOR_SRC_LOOP = 4'h4,
    AOR_SRC_TSIG1 = 4'h5,
    AOR_SRC_TSIG2 = 4'h6,
    AOR_SRC_PROGRAM_FINISHED = 4'h7,
    AOR_SRC_STAGE = 4'h8,
    AOR_SRC_INERR = 4'h9,
    AOR_SRC_ADERR = 4'ha
  } aor_src_e;

  localparam int AOR_NUM_SRC = 11;

  typedef enum logic [3:0] {
    AOR_AT_UPLO = 4'h1, AOR_AT_UP = 4'h2, AOR_AT_LO = 4'h3,
    AOR_AT_RANGE = 4'h4, AOR_AT_UPLO_SB = 4'h5, AOR_AT_UP_SB = 4'h6,
    AOR_AT_LO_SB = 4'h7, AOR_AT_ABS_UP = 4'h8, AOR_AT_ABS_LO = 4'h9,
    AOR_AT_ABS_UP_SB = 4'ha, AOR_AT_ABS_LO_SB = 4'hb
  } aor_atype_e;

  typedef enum logic [1:0] {
    AOR_CK_STD = 2'h0,
    AOR_CK_HEATCOOL = 2'h1,
    AOR_CK_POSITION = 2'h2
  } aor_kind_e;

  typedef enum logic [1:0] {
    AOR_KEY_IDLE = 2'h0,
    AOR_KEY_HOLD = 2'h1,
    AOR_KEY_MENU = 2'h2,
    AOR_KEY_MHOLD = 2'h3
  } aor_key_e;

  // ----------------------------------------------------------------
  // reset values and ranges
  // ----------------------------------------------------------------
  localparam aor_src_e AOR_AUX1_RST = AOR_SRC_ALARM2;
  localparam aor_src_e AOR_AUX2_RST = AOR_SRC_ALARM3;
  localparam aor_atype_e AOR_ATYPE_RST = AOR_AT_UP;
  localparam logic [2:0] AOR_POL_RST = 3'h0;
  localparam logic AOR_DIR_RST = 1'b0;
  localparam logic AOR_ONOFF_RST = 1'b0;
  localparam logic [1:0] AOR_SEC_RST = 2'h1;
  localparam logic [1:0] AOR_SEC_EXP_MAX = 2'h1;
  localparam logic signed [15:0] AOR_SPH_RST = 16'sd1300;
  localparam logic signed [15:0] AOR_SPL_RST = -16'sd200;
  localparam logic signed [15:0] AOR_SCH_RST = 16'sd100;
  localparam logic signed [15:0] AOR_SCL_RST = 16'sd0;
  localparam logic signed [15:0] AOR_SC_MAX = 16'sd9999;
  localparam logic signed [15:0] AOR_SC_MIN = -16'sd1999;
  localparam logic signed [15:0] AOR_TARGET_RST = 16'sd0;
  localparam logic [4:0] AOR_INTYPE_RST = 5'h02;
  localparam logic [4:0] AOR_TEMP_LAST = 5'h10;
  localparam logic [4:0] AOR_INTYPE_LAST = 5'h15;
  localparam logic [1:0] AOR_DP_RST = 2'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic converter_error;
    logic input_error_flag;
    logic stage_output;
    logic program_finished;
    logic [1:0] time_signal;
    logic loop_break_alarm;
    logic heater_burnout_alarm;
    logic [2:0] alarm_state;
  } aor_func_s;

  typedef struct packed {
    logic signed [15:0] hi;
    logic signed [15:0] lo;
    logic [1:0] dp;
  } aor_rng_s;

endpackage

// [aor_top_assertions.sv]
`timescale 1ns/1ps
module aor_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire aor_pkg::aor_func_s func_in,
  input wire logic mode_key,
  input wire logic [1:0] aux_out,
  input wire logic aux_out_one_lamp,
  input wire logic aux_out_two_lamp,
  input wire logic [3:0] alarm_one_type,
  input wire logic menu_active,
  input wire logic mode_enter
);
  import aor_pkg::*;
  // ------------------------------------------------------------
  // shadow of routing and polarity
  // ------------------------------------------------------------
  logic [3:0] r1_q;
  logic [3:0] r2_q;
  logic [2:0] pol_q;
  logic [1:0] lamp_q;
  logic [1:0] quiet_q;
  logic ok_w;
  assign ok_w = psel && penable && pready && !pslverr && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r1_q <= 4'h1;
      r2_q <= 4'h2;
      pol_q <= 3'h0;
    end else if (ok_w && paddr[7:0] == AOR_OFS_ROUTE) begin
      r1_q <= pwdata[3:0];
      r2_q <= pwdata[11:8];
    end else if (ok_w && paddr[7:0] == AOR_OFS_POL) begin
      pol_q <= pwdata[2:0];
    end
  end
  // config writes may take a cycle or two to land; skip the three cycles after each write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 2'h0;
    end else if (ok_w) begin
      quiet_q <= 2'h3;
    end else if (quiet_q != 2'h0) begin
      quiet_q <= quiet_q - 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_q <= 2'h0;
    end else begin
      lamp_q <= {func_in[r2_q], func_in[r1_q]};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  lamp_one_a:
    assert property (quiet_q == 2'h0 |-> aux_out_one_lamp == lamp_q[0])
    else $error("aux one lamp wrong");
  lamp_two_a:
    assert property (quiet_q == 2'h0 |-> aux_out_two_lamp == lamp_q[1])
    else $error("aux two lamp wrong");
  pol_one_a:
    assert property (quiet_q == 2'h0 |->
      aux_out[0] == (lamp_q[0] ^ (r1_q < 4'h3 && pol_q[r1_q])))
    else $error("aux one polarity wrong");
  pol_two_a:
    assert property (quiet_q == 2'h0 |->
      aux_out[1] == (lamp_q[1] ^ (r2_q < 4'h3 && pol_q[r2_q])))
    else $error("aux two polarity wrong");
  type_range_a:
    assert property (alarm_one_type inside {[4'h1:4'hb]})
    else $error("alarm one type out of range");
  unrouted_a:
    assert property (psel && !penable && pwrite &&
      paddr[7:0] == AOR_OFS_ATYPE && pwdata[3:0] != alarm_one_type &&
      r1_q != 4'h0 && r2_q != 4'h0 |=> pslverr)
    else $error("unrouted alarm type change accepted");
  enter_pulse_a:
    assert property (mode_enter |=> !mode_enter)
    else $error("mode enter longer than one cycle");
  enter_menu_a:
    assert property (mode_enter |-> $past(menu_active))
    else $error("mode enter without menu");
  menu_hold_a:
    assert property ($rose(menu_active) |-> $past(mode_key, 3))
    else $error("menu without key hold");
  cover property (mode_enter);
  cover property (aux_out[0] != aux_out_one_lamp);
  cover property (psel && penable && pslverr);
endmodule // aor_top_assertions

bind aor_top aor_top_assertions chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .func_in(func_in),
  .mode_key(mode_key), .aux_out(aux_out),
  .aux_out_one_lamp(aux_out_one_lamp), .aux_out_two_lamp(aux_out_two_lamp),
  .alarm_one_type(alarm_one_type), .menu_active(menu_active),
  .mode_enter(mode_enter));

// [aor_top_tb.sv]
`timescale 1ns/1ps
module aor_top_tb;
  import aor_pkg::*;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic mode_key = 1'b0;
  aor_func_s func_in = '0;
  logic signed [15:0] measured_value = 16'sh0;
  logic [31:0] prdata;
  logic pready, pslverr, lamp1, lamp2, onoff, menu, enter;
  logic [1:0] aux_out, dp;
  logic [3:0] at1;
  logic signed [15:0] target;
  logic signed [16:0] cerr;
  logic [31:0] rdat;
  logic rerr;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  always #10 pclk = ~pclk;
  aor_top #(.HOLD_CYC(20)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .func_in(func_in), .measured_value(measured_value),
    .mode_key(mode_key), .aux_out(aux_out), .aux_out_one_lamp(lamp1),
    .aux_out_two_lamp(lamp2), .alarm_one_type(at1), .alarm_two_type(),
    .alarm_three_type(), .target_value(target), .control_error(cerr),
    .onoff_active(onoff), .decimal_point(dp), .menu_active(menu),
    .mode_enter(enter));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic ck(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input e);
    apb(1'b1, a, d);
    ck(rerr, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    ck({rerr, rdat}, {1'b0, exp});
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_defaults;
    rd(AOR_OFS_ROUTE, 32'h201);
    rd(AOR_OFS_ATYPE, 32'h020202);
    rd(AOR_OFS_LIMIT, 32'hff38_0514);
    rd(AOR_OFS_SCALE, 32'h64);
    apb(1'b0, 8'h24, 32'h0);
    ck({rerr, rdat}, 33'h1_0000_0000);
    $display("defaults done");
  endtask
  task automatic t_route;
    for (int s = 0; s < AOR_NUM_SRC; s++) begin
      func_in <= aor_func_s'(11'h1 << s);
      wr(AOR_OFS_ROUTE, 32'h200 | s, 1'b0);
      settle();
      ck({lamp2, lamp1, aux_out[0]}, {s == 2, 2'b11});
    end
    wr(AOR_OFS_ROUTE, 32'h20b, 1'b1);
    wr(AOR_OFS_ROUTE, 32'h201, 1'b0);
    $display("route done");
  endtask
  task automatic t_pol;
    func_in <= aor_func_s'(11'h2);
    wr(AOR_OFS_POL, 32'h4, 1'b0);
    settle();
    ck({lamp2, lamp1, aux_out}, 4'h7);
    wr(AOR_OFS_POL, 32'h2, 1'b0);
    settle();
    ck({lamp2, lamp1, aux_out}, 4'h4);
    wr(AOR_OFS_POL, 32'h3, 1'b1);
    wr(AOR_OFS_POL, 32'h0, 1'b0);
    $display("polarity done");
  endtask
  task automatic t_types;
    wr(AOR_OFS_ATYPE, 32'h020203, 1'b1);
    wr(AOR_OFS_ROUTE, 32'h200, 1'b0);
    for (int c = 1; c <= 11; c++) begin
      wr(AOR_OFS_ATYPE, 32'h020200 | c, 1'b0);
      rd(AOR_OFS_ATYPE, 32'h020200 | c);
    end
    ck(at1, 32'hb);
    wr(AOR_OFS_ATYPE, 32'h02020c, 1'b1);
    wr(AOR_OFS_ATYPE, 32'h020200, 1'b1);
    wr(AOR_OFS_ROUTE, 32'h201, 1'b0);
    $display("types done");
  endtask
  task automatic t_limits;
    wr(AOR_OFS_TARGET, 32'd1301, 1'b1);
    wr(AOR_OFS_TARGET, 32'd1300, 1'b0);
    wr(AOR_OFS_LIMIT, 32'hff38_03e8, 1'b0);
    rd(AOR_OFS_TARGET, 32'd1000);
    ck(target, 32'd1000);
    wr(AOR_OFS_LIMIT, 32'h01f4_01f4, 1'b1);
    wr(AOR_OFS_LIMIT, 32'hff37_03e8, 1'b1);
    wr(AOR_OFS_INPUT, 32'h0, 1'b0);
    rd(AOR_OFS_LIMIT, 32'hf831_1964);
    settle();
    ck(dp, 32'h1);
    $display("limits done");
  endtask
  task automatic t_control;
    wr(AOR_OFS_TARGET, 32'd400, 1'b0);
    measured_value <= 16'sd600;
    wr(AOR_OFS_CTRL, 32'h101, 1'b0);
    settle();
    ck(cerr, 32'd200);
    wr(AOR_OFS_CTRL, 32'h102, 1'b0);
    settle();
    ck({onoff, cerr}, {1'b1, -17'sd200});
    wr(AOR_OFS_CTRL, 32'h122, 1'b0);
    settle();
    ck(onoff, 32'h0);
    wr(AOR_OFS_CTRL, 32'h120, 1'b1);
    wr(AOR_OFS_CTRL, 32'h202, 1'b0);
    wr(AOR_OFS_LIMIT, 32'hff38_03e8, 1'b1);
    wr(AOR_OFS_CTRL, 32'h200, 1'b1);
    $display("control done");
  endtask
  task automatic t_key;
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      @(posedge pclk);
      mode_key <= 1'b1;
      do begin
        @(negedge pclk);
        n++;
      end while ((k ? enter : menu) !== 1'b1 && n < 60);
      ck(n > 20 && n < 30, 32'h1);
      @(posedge pclk);
      mode_key <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    ck(menu, 32'h0);
    $display("key done");
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_route();
    t_pol();
    t_types();
    t_limits();
    t_control();
    t_key();
    give_verdict();
  end
endmodule // aor_top_tb
